// ---- src/cbr_map.svh ----
`ifndef CBR_MAP_SVH
`define CBR_MAP_SVH

// register offsets
`define CBR_REG_STRAP_HIGH_EN   8'h00
`define CBR_REG_EN_LOW_GROUP    8'h01
`define CBR_REG_EN_MID_GROUP    8'h02
`define CBR_REG_GATE_READBACK   8'h03
`define CBR_REG_RESERVED        8'h04

// byte 0 field positions
`define CBR_B0_PLL_MSB          7
`define CBR_B0_PLL_LSB          6
`define CBR_B0_EN_MSB           5
`define CBR_B0_EN_LSB           3
`define CBR_B0_FREQ             0

// reset values
`define CBR_ENABLE_RESET        19'h7ffff
`define CBR_PLL_RESET           2'h0
`define CBR_FREQ_RESET          1'h1

// three-level strap codes
`define CBR_LVL_LOW             2'h0
`define CBR_LVL_MID             2'h1
`define CBR_LVL_HIGH            2'h2

// pll readback codes
`define CBR_PLL_NARROW          2'h0
`define CBR_PLL_BYPASS          2'h1
`define CBR_PLL_WIDE            2'h3

// slave addresses, write form
`define CBR_ADDR_LL             8'hd8
`define CBR_ADDR_LM             8'hda
`define CBR_ADDR_LH             8'hde
`define CBR_ADDR_ML             8'hc2
`define CBR_ADDR_MM             8'hc4
`define CBR_ADDR_MH             8'hc6
`define CBR_ADDR_HL             8'hca
`define CBR_ADDR_HM             8'hcc
`define CBR_ADDR_HH             8'hce

// timing
`define CBR_CLK_MHZ             200
`define CBR_BUS_MAX_KBPS        400
`define CBR_CYCLES_PER_BIT      ((`CBR_CLK_MHZ * 1000) / `CBR_BUS_MAX_KBPS)

`endif

// ---- src/cbr_pkg.sv ----
package cbr_pkg;

    typedef enum logic [2:0] {
        CBR_IDLE,
        CBR_ADDR,
        CBR_CMD,
        CBR_WRITE,
        CBR_READ,
        CBR_ACK,
        CBR_MACK
    } cbr_state_t;

    typedef struct packed {
        cbr_state_t  state;
        cbr_state_t  after_ack;
        logic [7:0]  shreg;
        logic [3:0]  bitcnt;
        logic [7:0]  ptr;
        logic        sda_low;
        logic        scl_q;
        logic        sda_q;
        logic        mack_ok;
        logic        latched;
        logic [1:0]  pll_mode;
        logic        freq_100m;
        logic [18:0] enable;
        logic [18:0] run;
    } cbr_regs_t;

endpackage : cbr_pkg

// ---- src/cbr_regs.sv ----
`timescale 1ns/100ps
`include "cbr_map.svh"

module cbr_regs
    import cbr_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_RESET_N,
    input  wire logic        I_SCL,
    input  wire logic        I_SDA,
    output logic             O_SDA,
    output logic             O_SDA_OE,
    input  wire logic [1:0]  I_ADDR_STRAP_HIGH,
    input  wire logic [1:0]  I_ADDR_STRAP_LOW,
    input  wire logic [1:0]  I_PLL_MODE_STRAP,
    input  wire logic        I_FREQ_SELECT_STRAP,
    input  wire logic        I_POWER_DOWN_INPUT_N,
    input  wire logic [12:5] I_GATE_N,
    output logic [18:0]      O_PAIR_RUN,
    output logic [1:0]       O_PLL_MODE,
    output logic             O_FREQ_100M
);

    cbr_regs_t r;
    cbr_regs_t next_r;

    logic [7:0] slave_addr;
    logic [7:0] rd_data;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;

    // slave address decode
    always_comb begin
        case ({I_ADDR_STRAP_HIGH, I_ADDR_STRAP_LOW})
            {`CBR_LVL_LOW,  `CBR_LVL_LOW}:  slave_addr = `CBR_ADDR_LL;
            {`CBR_LVL_LOW,  `CBR_LVL_MID}:  slave_addr = `CBR_ADDR_LM;
            {`CBR_LVL_LOW,  `CBR_LVL_HIGH}: slave_addr = `CBR_ADDR_LH;
            {`CBR_LVL_MID,  `CBR_LVL_LOW}:  slave_addr = `CBR_ADDR_ML;
            {`CBR_LVL_MID,  `CBR_LVL_MID}:  slave_addr = `CBR_ADDR_MM;
            {`CBR_LVL_MID,  `CBR_LVL_HIGH}: slave_addr = `CBR_ADDR_MH;
            {`CBR_LVL_HIGH, `CBR_LVL_LOW}:  slave_addr = `CBR_ADDR_HL;
            {`CBR_LVL_HIGH, `CBR_LVL_MID}:  slave_addr = `CBR_ADDR_HM;
            default:                        slave_addr = `CBR_ADDR_HH;
        endcase
    end

    // read data mux
    always_comb begin
        rd_data = 8'h00;
        if (r.ptr == `CBR_REG_STRAP_HIGH_EN) begin
            rd_data[`CBR_B0_PLL_MSB:`CBR_B0_PLL_LSB] = r.pll_mode;
            rd_data[`CBR_B0_FREQ] = r.freq_100m;
            rd_data[`CBR_B0_EN_MSB:`CBR_B0_EN_LSB] = r.enable[18:16];
        end else if (r.ptr == `CBR_REG_EN_LOW_GROUP) begin
            rd_data = r.enable[7:0];
        end else if (r.ptr == `CBR_REG_EN_MID_GROUP) begin
            rd_data = r.enable[15:8];
        end else if (r.ptr == `CBR_REG_GATE_READBACK) begin
            rd_data = I_GATE_N[12:5];
        end else begin
            rd_data = 8'h00;
        end
    end

    // 500 clocks per bit at full rate
    assign scl_rise   = I_SCL & ~r.scl_q;
    assign scl_fall   = ~I_SCL & r.scl_q;
    assign start_seen = I_SCL & r.scl_q & r.sda_q & ~I_SDA;
    assign stop_seen  = I_SCL & r.scl_q & ~r.sda_q & I_SDA;

    always_comb begin
        next_r = r;
        next_r.scl_q = I_SCL;
        next_r.sda_q = I_SDA;

        if (!r.latched) begin
            next_r.latched   = 1'b1;
            next_r.freq_100m = I_FREQ_SELECT_STRAP;
            case (I_PLL_MODE_STRAP)
                `CBR_LVL_LOW:  next_r.pll_mode = `CBR_PLL_NARROW;
                `CBR_LVL_MID:  next_r.pll_mode = `CBR_PLL_BYPASS;
                default:       next_r.pll_mode = `CBR_PLL_WIDE;
            endcase
        end

        if (!I_POWER_DOWN_INPUT_N) begin
            next_r.state   = CBR_IDLE;
            next_r.sda_low = 1'b0;
        end else if (start_seen) begin
            next_r.state   = CBR_ADDR;
            next_r.bitcnt  = 4'h0;
            next_r.sda_low = 1'b0;
        end else if (stop_seen) begin
            next_r.state   = CBR_IDLE;
            next_r.sda_low = 1'b0;
        end else begin
            case (r.state)
                CBR_ADDR, CBR_CMD, CBR_WRITE: begin
                    if (scl_rise && r.bitcnt < 4'h8) begin
                        next_r.shreg  = {r.shreg[6:0], I_SDA};
                        next_r.bitcnt = r.bitcnt + 4'h1;
                    end else if (scl_fall && r.bitcnt == 4'h8) begin
                        next_r.bitcnt  = 4'h0;
                        next_r.state   = CBR_ACK;
                        next_r.sda_low = 1'b1;
                        if (r.state == CBR_ADDR) begin
                            if (r.shreg[7:1] != slave_addr[7:1]) begin
                                next_r.state   = CBR_IDLE;
                                next_r.sda_low = 1'b0;
                            end else if (r.shreg[0]) begin
                                next_r.after_ack = CBR_READ;
                            end else begin
                                next_r.after_ack = CBR_CMD;
                            end
                        end else if (r.state == CBR_CMD) begin
                            next_r.ptr       = r.shreg;
                            next_r.after_ack = CBR_WRITE;
                        end else begin
                            if (r.ptr == `CBR_REG_STRAP_HIGH_EN) begin
                                next_r.enable[18:16] = r.shreg[`CBR_B0_EN_MSB:`CBR_B0_EN_LSB];
                            end else if (r.ptr == `CBR_REG_EN_LOW_GROUP) begin
                                next_r.enable[7:0] = r.shreg;
                            end else if (r.ptr == `CBR_REG_EN_MID_GROUP) begin
                                next_r.enable[15:8] = r.shreg;
                            end
                            next_r.ptr       = r.ptr + 8'h01;
                            next_r.after_ack = CBR_WRITE;
                        end
                    end
                end
                CBR_ACK: begin
                    if (scl_fall) begin
                        next_r.sda_low = 1'b0;
                        next_r.state   = r.after_ack;
                        if (r.after_ack == CBR_READ) begin
                            next_r.shreg   = rd_data;
                            next_r.ptr     = r.ptr + 8'h01;
                            next_r.sda_low = ~rd_data[7];
                        end
                    end
                end
                CBR_READ: begin
                    if (scl_rise) begin
                        next_r.bitcnt = r.bitcnt + 4'h1;
                    end else if (scl_fall && r.bitcnt == 4'h8) begin
                        next_r.bitcnt  = 4'h0;
                        next_r.sda_low = 1'b0;
                        next_r.state   = CBR_MACK;
                    end else if (scl_fall) begin
                        next_r.shreg   = {r.shreg[6:0], 1'b0};
                        next_r.sda_low = ~r.shreg[6];
                    end
                end
                CBR_MACK: begin
                    if (scl_rise) begin
                        next_r.mack_ok = ~I_SDA;
                    end else if (scl_fall && r.mack_ok) begin
                        next_r.state   = CBR_READ;
                        next_r.shreg   = rd_data;
                        next_r.ptr     = r.ptr + 8'h01;
                        next_r.sda_low = ~rd_data[7];
                    end else if (scl_fall) begin
                        next_r.state = CBR_IDLE;
                    end
                end
                default: begin
                    next_r.sda_low = 1'b0;
                end
            endcase
        end

        next_r.run        = r.enable;
        next_r.run[12:5]  = r.enable[12:5] & ~I_GATE_N[12:5];
        if (!I_POWER_DOWN_INPUT_N) begin
            next_r.run = 19'h00000;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            r.state     <= CBR_IDLE;
            r.after_ack <= CBR_IDLE;
            r.shreg     <= 8'h00;
            r.bitcnt    <= 4'h0;
            r.ptr       <= 8'h00;
            r.sda_low   <= 1'b0;
            r.scl_q     <= 1'b1;
            r.sda_q     <= 1'b1;
            r.mack_ok   <= 1'b0;
            r.latched   <= 1'b0;
            r.pll_mode  <= `CBR_PLL_RESET;
            r.freq_100m <= `CBR_FREQ_RESET;
            r.enable    <= `CBR_ENABLE_RESET;
            r.run       <= 19'h00000;
        end else begin
            r <= next_r;
        end
    end

    assign O_SDA       = 1'b0;
    assign O_SDA_OE    = r.sda_low;
    assign O_PAIR_RUN  = r.run;
    assign O_PLL_MODE  = r.pll_mode;
    assign O_FREQ_100M = r.freq_100m;

endmodule : cbr_regs

// ---- bench/cbr_regs_chk.sv ----
`timescale 1ns/100ps
module cbr_regs_chk (
    input wire logic        I_CLK,
    input wire logic        I_RESET_N,
    input wire logic        I_SCL,
    input wire logic        I_SDA,
    input wire logic        O_SDA,
    input wire logic        O_SDA_OE,
    input wire logic [1:0]  I_ADDR_STRAP_HIGH,
    input wire logic [1:0]  I_ADDR_STRAP_LOW,
    input wire logic [1:0]  I_PLL_MODE_STRAP,
    input wire logic        I_FREQ_SELECT_STRAP,
    input wire logic        I_POWER_DOWN_INPUT_N,
    input wire logic [12:5] I_GATE_N,
    input wire logic [18:0] O_PAIR_RUN,
    input wire logic [1:0]  O_PLL_MODE,
    input wire logic        O_FREQ_100M
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESET_N);
    a_pd_sda_off: assert property ((!I_POWER_DOWN_INPUT_N) [*2] |-> !O_SDA_OE) else $error("sda driven");
    a_pd_pairs_off: assert property (!$past(I_POWER_DOWN_INPUT_N) |-> O_PAIR_RUN == 19'h00000)
        else $error("pair runs in power-down");
    a_gate_blocks: assert property (1'b1 |=> (O_PAIR_RUN[12:5] & $past(I_GATE_N)) == 8'h00)
        else $error("gated pair runs");
    a_pll_latch: assert property ($rose(I_RESET_N) |=>
        O_PLL_MODE == {$past(I_PLL_MODE_STRAP[1]), |$past(I_PLL_MODE_STRAP)}) else $error("pll readback code");
    a_freq_latch: assert property ($rose(I_RESET_N) |=> O_FREQ_100M == $past(I_FREQ_SELECT_STRAP))
        else $error("freq strap latch");
    a_strap_kept: assert property ($past(I_RESET_N, 2) |-> $stable(O_PLL_MODE) && $stable(O_FREQ_100M))
        else $error("latched strap moved");
    a_enable_reset: assert property ($rose(I_RESET_N) && I_POWER_DOWN_INPUT_N |=>
        O_PAIR_RUN == {6'h3f, ~$past(I_GATE_N), 5'h1f}) else $error("enables not set by reset");
    a_sda_timing: assert property ($changed(O_SDA_OE) && I_POWER_DOWN_INPUT_N && $past(I_POWER_DOWN_INPUT_N)
        |-> !$past(I_SCL) && $past(I_SCL, 2)) else $error("sda moved off scl fall");
endmodule : cbr_regs_chk
bind cbr_regs cbr_regs_chk cbr_regs_chk_inst (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_SCL(I_SCL), .I_SDA(I_SDA),
    .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE), .I_ADDR_STRAP_HIGH(I_ADDR_STRAP_HIGH), .I_ADDR_STRAP_LOW(I_ADDR_STRAP_LOW),
    .I_PLL_MODE_STRAP(I_PLL_MODE_STRAP), .I_FREQ_SELECT_STRAP(I_FREQ_SELECT_STRAP), .I_GATE_N(I_GATE_N),
    .I_POWER_DOWN_INPUT_N(I_POWER_DOWN_INPUT_N), .O_PAIR_RUN(O_PAIR_RUN), .O_PLL_MODE(O_PLL_MODE),
    .O_FREQ_100M(O_FREQ_100M));

// ---- bench/cbr_host_model.sv ----
`timescale 1ns/100ps
module cbr_host_model (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_pull
);
    // quarter bit, 500 clocks a bit
    localparam int QUARTER = 125;
    initial begin
        o_scl      = 1'b1;
        o_sda_pull = 1'b0;
    end
    task automatic step(input logic c, input logic p);
        o_scl      = c;
        o_sda_pull = p;
        repeat (QUARTER) @(negedge i_clk);
    endtask : step
    task automatic start_cond;
        if (o_scl == 1'b0) begin
            step(1'b0, 1'b0);
            step(1'b1, 1'b0);
        end
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask : start_cond
    task automatic stop_cond;
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : stop_cond
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ack);
        logic [8:0] o;
        o = {d, a};
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, ~o[i]);
            step(1'b1, o_sda_pull);
            o[i] = i_sda;
            step(1'b1, o_sda_pull);
            step(1'b0, o_sda_pull);
        end
        r   = o[8:1];
        ack = o[0];
    endtask : xfer
endmodule : cbr_host_model

// ---- bench/cbr_regs_tb_top.sv ----
`timescale 1ns/100ps
`include "cbr_map.svh"
module cbr_regs_tb_top;
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic [1:0]  s_hi   = 2'h0;
    logic [1:0]  s_lo   = 2'h0;
    logic        pd_n   = 1'b1;
    logic [1:0]  pll_s  = 2'h1;
    logic        freq_s = 1'b0;
    logic        sda_out;
    logic [7:0]  gate_n = 8'h96;
    logic        scl, pull, oe, f100, ack;
    logic [18:0] run;
    logic [1:0]  pll;
    logic [7:0]  rd;
    int          n_fail = 0;
    int          comparisons = 0;
    wire         sda = (oe ? sda_out : 1'b1) & ~pull;
    localparam logic [7:0]  ADDRS [7] = '{`CBR_ADDR_LL, `CBR_ADDR_LM, `CBR_ADDR_LH, `CBR_ADDR_ML, `CBR_ADDR_MM,
                                          `CBR_ADDR_MH, `CBR_ADDR_HL};
    localparam logic [7:0]  WR [5] = '{`CBR_ADDR_HM, 8'h00, 8'hc7, 8'h5a, 8'ha5};
    localparam logic [7:0]  RD [5] = '{8'h40, 8'h5a, 8'ha5, 8'h96, 8'h00};
    localparam logic [18:0] EN = {3'h0, 8'ha5, 8'h5a};
    always #2.5 clk = ~clk;
    cbr_regs cbr_regs_inst (.I_CLK(clk), .I_RESET_N(rst_n), .I_SCL(scl), .I_SDA(sda), .O_SDA(sda_out),
        .O_SDA_OE(oe), .I_ADDR_STRAP_HIGH(s_hi), .I_ADDR_STRAP_LOW(s_lo), .I_PLL_MODE_STRAP(pll_s),
        .I_FREQ_SELECT_STRAP(freq_s), .I_POWER_DOWN_INPUT_N(pd_n), .I_GATE_N(gate_n), .O_PAIR_RUN(run),
        .O_PLL_MODE(pll), .O_FREQ_100M(f100));
    cbr_host_model cbr_host_model_inst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
    task automatic cmp(input string what, input logic [18:0] exp, input logic [18:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    task automatic send(input logic [7:0] b, input logic exp_nack);
        cbr_host_model_inst.xfer(b, 1'b1, rd, ack);
        cmp("ack slot", {18'h0, exp_nack}, {18'h0, ack});
    endtask : send
    task automatic restart(input logic [1:0] mode, input logic freq, input logic [1:0] exp_mode);
        rst_n  = 1'b0;
        pll_s  = mode;
        freq_s = freq;
        repeat (4) @(negedge clk);
        rst_n  = 1'b1;
        repeat (2) @(negedge clk);
        cmp("run after reset", {6'h3f, ~gate_n, 5'h1f}, run);
        cmp("pll mode", {17'h0, exp_mode}, {17'h0, pll});
        cmp("freq strap", {18'h0, freq}, {18'h0, f100});
    endtask : restart
    initial begin
        repeat (105000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    initial begin
        restart(2'h1, 1'b0, 2'h1);
        cbr_host_model_inst.start_cond();
        send(`CBR_ADDR_LM, 1'b1);
        cbr_host_model_inst.stop_cond();
        for (int k = 0; k < 7; k++) begin
            s_hi = 2'(k / 3);
            s_lo = 2'(k % 3);
            cbr_host_model_inst.start_cond();
            send(ADDRS[k], 1'b0);
            cbr_host_model_inst.stop_cond();
        end
        $display("address test done");
        s_hi = 2'h2;
        s_lo = 2'h1;
        cbr_host_model_inst.start_cond();
        foreach (WR[i]) begin
            send(WR[i], 1'b0);
        end
        cbr_host_model_inst.stop_cond();
        cmp("run after write", EN & ~{6'h0, gate_n, 5'h0}, run);
        cmp("pll kept", 19'h1, {17'h0, pll});
        $display("write test done");
        s_lo = 2'h2;
        cbr_host_model_inst.start_cond();
        send(`CBR_ADDR_HH, 1'b0);
        send(8'h00, 1'b0);
        cbr_host_model_inst.start_cond();
        send(`CBR_ADDR_HH | 8'h01, 1'b0);
        foreach (RD[i]) begin
            cbr_host_model_inst.xfer(8'hff, i == 4, rd, ack);
            cmp("read byte", {11'h0, RD[i]}, {11'h0, rd & (i == 0 ? 8'hf9 : 8'hff)});
        end
        cbr_host_model_inst.stop_cond();
        $display("read test done");
        gate_n = 8'h00;
        repeat (2) @(negedge clk);
        cmp("run ungated", EN, run);
        pd_n = 1'b0;
        repeat (2) @(negedge clk);
        cmp("run in power-down", 19'h0, run);
        cmp("sda in power-down", 19'h0, {18'h0, oe});
        pd_n = 1'b1;
        repeat (2) @(negedge clk);
        cmp("run after power-down", EN, run);
        $display("power-down test done");
        restart(2'h2, 1'b1, 2'h3);
        restart(2'h0, 1'b1, 2'h0);
        $display("reset test done");
        report_and_stop();
    end
endmodule : cbr_regs_tb_top
